// ==== rtl/csr_status_regs.vh ====
// constants for the core status register block
`ifndef CSR_STATUS_REGS_VH
`define CSR_STATUS_REGS_VH
`define CSR_STATUS_ADDR 5'h03
`define CSR_GPR07_ADDR 5'h07
`define CSR_BIT_SPARE 7
`define CSR_BIT_PAGE_HI 6
`define CSR_BIT_PAGE_LO 5
`define CSR_BIT_TIMEOUT 4
`define CSR_BIT_POWERDOWN 3
`define CSR_BIT_ZERO 2
`define CSR_BIT_DIGIT_CARRY 1
`define CSR_BIT_CARRY 0
`define CSR_STATUS_RESET 8'h18
`define CSR_GPR07_RESET 8'h00
`define CSR_PAGE_WORDS 12'h200
`endif

// ==== rtl/csr_status.v ====
// core status register with flag masking, reset cause and page preselect
// Notes on behaviour
// - one register holds flags, cause, page
// - status writable like any file register
// - flag-updating ops keep alu flag values
// - time-out and power-down ignore writes
// - clear-file zeroes page bits, sets zero
// - page bits select 512-word program page
// - each page spans 512 instruction words
// - power-on: page 0, cause flags 1
// - unimplemented addresses read as zero
// - upper pc bits not software accessible
// - address 07h is a plain data register
`timescale 1ns/10ps
`include "csr_status_regs.vh"
module csr_status (
    // clock and reset
    input wire core_clk,
    input wire srst,
    // file register access from the execution unit
    input wire [4:0] file_addr,
    input wire file_wr,
    input wire [7:0] file_wdata,
    input wire clear_file_op,
    output reg [7:0] file_rdata,
    // alu flag update
    input wire flags_upd_zero,
    input wire flags_upd_dc,
    input wire flags_upd_carry,
    input wire alu_zero,
    input wire alu_digit_carry,
    input wire alu_carry,
    // reset cause events from reset and sleep logic
    input wire watchdog_clear_op,
    input wire sleep_op,
    input wire watchdog_timeout,
    // status view
    output wire [7:0] core_flags_and_page,
    output reg [10:0] page_base
);

// status byte and the plain data register at 07h
reg [7:0] status;
reg [7:0] gpr07;
reg [7:0] next_status;
reg [7:0] next_gpr07;
// per-field next values, merged into next_status
reg [2:0] next_page;
reg [1:0] next_cause;
reg [2:0] next_alu;
// current field groups of the stored byte and of the write data
wire [2:0] page_hold;
wire [1:0] cause_hold;
wire [2:0] alu_hold;
wire [2:0] alu_data;
// access decode
wire sel_status;
wire sel_gpr07;
wire clr_status;
wire data_status;
wire any_flag_upd;
wire flag_data_wr;
wire wr_gpr07;
wire clr_gpr07;

// bit positions inside the three-bit and two-bit field groups
localparam PAGE_SPARE = 2;
localparam PAGE_HI = 1;
localparam PAGE_LO = 0;
localparam CAUSE_TIMEOUT = 1;
localparam CAUSE_POWERDOWN = 0;
localparam ALU_ZERO = 2;
localparam ALU_DIGIT_CARRY = 1;
localparam ALU_CARRY = 0;

// true when the access names the given file address
function csr_addr_hit;
    input [4:0] addr;
    input [4:0] target;
    begin
        csr_addr_hit = (addr == target);
    end
endfunction

// page group of a byte: spare, high and low page bits
function [2:0] csr_page_of;
    input [7:0] value;
    begin
        csr_page_of[PAGE_SPARE] = value[`CSR_BIT_SPARE];
        csr_page_of[PAGE_HI] = value[`CSR_BIT_PAGE_HI];
        csr_page_of[PAGE_LO] = value[`CSR_BIT_PAGE_LO];
    end
endfunction

// reset-cause group of a byte: time-out and power-down
function [1:0] csr_cause_of;
    input [7:0] value;
    begin
        csr_cause_of[CAUSE_TIMEOUT] = value[`CSR_BIT_TIMEOUT];
        csr_cause_of[CAUSE_POWERDOWN] = value[`CSR_BIT_POWERDOWN];
    end
endfunction

// alu group of a byte: zero, digit carry and carry
function [2:0] csr_alu_of;
    input [7:0] value;
    begin
        csr_alu_of[ALU_ZERO] = value[`CSR_BIT_ZERO];
        csr_alu_of[ALU_DIGIT_CARRY] = value[`CSR_BIT_DIGIT_CARRY];
        csr_alu_of[ALU_CARRY] = value[`CSR_BIT_CARRY];
    end
endfunction

// assemble the register byte from its three field groups
function [7:0] csr_pack;
    input [2:0] page;
    input [1:0] cause;
    input [2:0] alu;
    begin
        csr_pack[`CSR_BIT_SPARE] = page[PAGE_SPARE];
        csr_pack[`CSR_BIT_PAGE_HI] = page[PAGE_HI];
        csr_pack[`CSR_BIT_PAGE_LO] = page[PAGE_LO];
        csr_pack[`CSR_BIT_TIMEOUT] = cause[CAUSE_TIMEOUT];
        csr_pack[`CSR_BIT_POWERDOWN] = cause[CAUSE_POWERDOWN];
        csr_pack[`CSR_BIT_ZERO] = alu[ALU_ZERO];
        csr_pack[`CSR_BIT_DIGIT_CARRY] = alu[ALU_DIGIT_CARRY];
        csr_pack[`CSR_BIT_CARRY] = alu[ALU_CARRY];
    end
endfunction

// one alu flag: an alu update wins, then a plain data write, else hold
function csr_flag_next;
    input hold;
    input data;
    input alu_value;
    input data_wr;
    input alu_upd;
    begin
        if (alu_upd)
        begin
            csr_flag_next = alu_value;
        end
        else if (data_wr)
        begin
            csr_flag_next = data;
        end
        else
        begin
            csr_flag_next = hold;
        end
    end
endfunction

// event flag: the clear event wins over the set event, else hold
function csr_set_clear;
    input hold;
    input set_ev;
    input clear_ev;
    begin
        if (clear_ev)
        begin
            csr_set_clear = 1'b0;
        end
        else if (set_ev)
        begin
            csr_set_clear = 1'b1;
        end
        else
        begin
            csr_set_clear = hold;
        end
    end
endfunction

// the two page bits pick one of four program pages
// the low nine bits span one 512-word page
function [10:0] csr_page_base;
    input [7:0] value;
    begin
        csr_page_base = {value[`CSR_BIT_PAGE_HI], value[`CSR_BIT_PAGE_LO], 9'h000};
    end
endfunction

// both selects come from the one decode function
assign sel_status = csr_addr_hit(file_addr, `CSR_STATUS_ADDR);
assign sel_gpr07 = csr_addr_hit(file_addr, `CSR_GPR07_ADDR);
// status takes a data write like any file register
// clear-file beats a data write that lands in the same cycle
assign clr_status = sel_status & clear_file_op;
assign data_status = sel_status & file_wr & ~clear_file_op;
assign any_flag_upd = flags_upd_zero | flags_upd_dc | flags_upd_carry;
// a flag-updating op blocks the data write to all three flags
assign flag_data_wr = data_status & ~any_flag_upd;
// 07h is plain storage, cleared the same way as status
assign wr_gpr07 = sel_gpr07 & file_wr & ~clear_file_op;
assign clr_gpr07 = sel_gpr07 & clear_file_op;
assign page_hold = csr_page_of(status);
assign cause_hold = csr_cause_of(status);
assign alu_hold = csr_alu_of(status);
assign alu_data = csr_alu_of(file_wdata);

// the page bits do not follow the pc across a page edge
always @*
begin
    next_page = page_hold;
    if (clr_status)
    begin
        // clear-file zeroes all three page bits
        next_page = 3'b000;
    end
    else if (data_status)
    begin
        next_page = csr_page_of(file_wdata);
    end
end

// the cause flags never take file write data
always @*
begin
    // a watchdog time-out wins over clear or sleep
    next_cause[CAUSE_TIMEOUT] = csr_set_clear(cause_hold[CAUSE_TIMEOUT], watchdog_clear_op | sleep_op,
        watchdog_timeout);
    // power-down falls on sleep and rises on a watchdog clear
    next_cause[CAUSE_POWERDOWN] = csr_set_clear(cause_hold[CAUSE_POWERDOWN], watchdog_clear_op, sleep_op);
end

// a flag op aimed at another file still updates the flags
always @*
begin
    // each updated flag takes its alu value over any data
    next_alu[ALU_ZERO] = csr_flag_next(alu_hold[ALU_ZERO], alu_data[ALU_ZERO], alu_zero,
        flag_data_wr, flags_upd_zero);
    next_alu[ALU_DIGIT_CARRY] = csr_flag_next(alu_hold[ALU_DIGIT_CARRY], alu_data[ALU_DIGIT_CARRY],
        alu_digit_carry, flag_data_wr, flags_upd_dc);
    next_alu[ALU_CARRY] = csr_flag_next(alu_hold[ALU_CARRY], alu_data[ALU_CARRY], alu_carry,
        flag_data_wr, flags_upd_carry);
    // clear-file sets zero even when the alu updates it
    if (clr_status)
    begin
        next_alu[ALU_ZERO] = 1'b1;
    end
end

// holds its value until written or cleared
always @*
begin
    next_gpr07 = gpr07;
    if (clr_gpr07)
    begin
        next_gpr07 = 8'h00;
    end
    else if (wr_gpr07)
    begin
        next_gpr07 = file_wdata;
    end
end

// one byte carries flags, reset cause and page bits
// groups merge last so that each group keeps a single writer
always @*
begin
    next_status = csr_pack(next_page, next_cause, next_alu);
end

// power-on value; the alu flags are undefined, zero chosen
always @(posedge core_clk)
begin
    if (srst)
    begin
        status <= `CSR_STATUS_RESET;
        gpr07 <= `CSR_GPR07_RESET;
    end
    else
    begin
        status <= next_status;
        gpr07 <= next_gpr07;
    end
end

// addresses outside this block read as zero
// combinational so an instruction reads its operand in its own cycle
always @*
begin
    if (sel_status)
    begin
        file_rdata = status;
    end
    else if (sel_gpr07)
    begin
        file_rdata = gpr07;
    end
    else
    begin
        file_rdata = 8'h00;
    end
end

assign core_flags_and_page = status;

// upper pc bits leave only as this base, never as a file
always @*
begin
    page_base = csr_page_base(status);
end

endmodule // csr_status

// ==== tb/csr_alu_model.sv ====
// alu flag model of the execution unit
`timescale 1ns/10ps
module csr_alu_model (
    input wire [7:0] res,
    output wire [2:0] flg
);
    assign flg = {res == 8'h00, res[4], res[7]};
endmodule // csr_alu_model

// ==== tb/csr_status_properties.sv ====
// assertion checker for the status register
`timescale 1ns/10ps
module csr_status_props (
    input wire core_clk, srst, file_wr, clear_file_op, flags_upd_carry, alu_carry,
    input wire sleep_op, watchdog_timeout, watchdog_clear_op, flags_upd_dc,
    input wire [4:0] file_addr,
    input wire [7:0] file_wdata, file_rdata, core_flags_and_page,
    input wire [10:0] page_base
);
    wire [7:0] c = core_flags_and_page;
    wire a3 = file_addr == 5'h03;
    wire ev = sleep_op | watchdog_timeout | watchdog_clear_op;
    wire g7 = file_addr == 5'h07;
    wire dw = file_wr & a3 & ~clear_file_op;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    cause_hold_a: assert property (file_wr && a3 && !ev |=> $stable(c[4:3])) else $error("cause");
    data_wr_a: assert property (file_wr && a3 && !clear_file_op |=> c[7:5] == $past(file_wdata[7:5]))
        else $error("data");
    alu_mask_a: assert property (flags_upd_carry |=> c[0] == $past(alu_carry)) else $error("mask");
    clear_op_a: assert property (clear_file_op && a3 |=> c[7:5] == 3'h0 && c[2]) else $error("clr");
    page_map_a: assert property (page_base == {c[6:5], 9'h000}) else $error("page");
    read_back_a: assert property (a3 |-> file_rdata == c) else $error("rd");
    unimpl_zero_a: assert property (!a3 && file_addr != 5'h07 |-> file_rdata == 8'h00) else $error("un");
    wdt_cause_a: assert property (watchdog_timeout |=> !c[4]) else $error("to");
    dc_mask_a: assert property (dw && flags_upd_carry && !flags_upd_dc |=> $stable(c[1])) else $error("dc");
    gpr_store_a: assert property (file_wr && !clear_file_op && g7 ##1 g7 |-> file_rdata == $past(file_wdata))
        else $error("gpr");
    pd_sleep_a: assert property (sleep_op |=> !c[3]) else $error("pd");
    cover property (clear_file_op && a3);
    cover property (file_wr && a3 && flags_upd_carry);
    cover property (watchdog_timeout);
endmodule // csr_status_props
bind csr_status csr_status_props u_csr_status_props (.*);

// ==== tb/csr_status_tb.sv ====
// self-checking bench for the status register
`timescale 1ns/10ps
module csr_status_tb;
    reg core_clk = 0, srst = 1, wr = 0, cl = 0, uz = 0, ud = 0, uc = 0, sl = 0, wc = 0, wt = 0;
    reg [4:0] ad = 0;
    reg [7:0] wd = 0, s = 8'h18;
    reg [31:0] r = 32'hf1af_761c;
    wire [7:0] rd, st;
    wire [2:0] f;
    integer error_cnt = 0, compares = 0, i;
    reg [7:0] q[$];
    function [31:0] lfsr_next;
        input [31:0] v;
        begin
            lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
        end
    endfunction
    always #50 core_clk = ~core_clk;
    csr_alu_model u_csr_alu_model (.res(wd), .flg(f));
    csr_status u_csr_status (.core_clk(core_clk), .srst(srst), .file_addr(ad), .file_wr(wr), .file_wdata(wd),
        .clear_file_op(cl), .file_rdata(rd), .flags_upd_zero(uz), .flags_upd_dc(ud), .flags_upd_carry(uc),
        .alu_zero(f[2]), .alu_digit_carry(f[1]), .alu_carry(f[0]), .watchdog_clear_op(wc), .sleep_op(sl),
        .watchdog_timeout(wt), .core_flags_and_page(st), .page_base());
    always @(negedge core_clk)
        if (q.size() > 0)
        begin
            compares = compares + 1;
            if (st !== q.pop_front())
            begin
                error_cnt = error_cnt + 1;
                $display("MISMATCH %0t status", $time);
            end
        end
    task finish_test;
        begin
            $display("checks %0d errors %0d", compares, error_cnt);
            if (error_cnt == 0 && compares > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial
    begin
        repeat (10) @(negedge core_clk);
        srst = 0;
        q.push_back(8'h18);
        for (i = 0; i < 80; i = i + 1)
        begin
            @(negedge core_clk);
            r = lfsr_next(r);
            // page bits written only as page select
            ad = r[1] ? 5'h03 : r[9] ? 5'h07 : r[8:4];
            {wd, wr, cl} = {r[23:16], r[3], r[2] & ~r[3]};
            // clear-file ops drive no flag update
            {uz, ud, uc} = cl ? 3'h0 : r[12:10];
            {wt, sl, wc} = 3'h4 >> r[14:13];
            #1;
            if (ad == 5'h03 && cl)
                s = {3'h0, s[4:3], 1'b1, s[1:0]};
            else if (ad == 5'h03 && wr)
                s = {wd[7:5], s[4:3], (uz | ud | uc) ? s[2:0] : wd[2:0]};
            s[2:0] = {uz ? f[2] : s[2], ud ? f[1] : s[1], uc ? f[0] : s[0]};
            s[4] = wt ? 1'b0 : (sl | wc) ? 1'b1 : s[4];
            s[3] = sl ? 1'b0 : wc ? 1'b1 : s[3];
            @(posedge core_clk);
            #1 q.push_back(s);
        end
        repeat (2) @(negedge core_clk);
        finish_test;
    end
endmodule // csr_status_tb
